// [lcdc_pkg.sv]
// Purpose: shared constants and types for the display-control decoder
// Assumes: 200 MHz clock, nominal oscillator 270 kHz
// Notes: register window reached over classic wishbone
package lcdc_pkg;
    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [3:0] ADR_CMD = 4'h0;
    localparam logic [3:0] ADR_STATUS = 4'h4;
    localparam logic [3:0] ADR_CONFIG = 4'h8;
    localparam logic [3:0] ADR_ADDR = 4'hC;
    // ----------------------------------------
    // config field positions
    // ----------------------------------------
    localparam int CFG_DISPLAY = 0;
    localparam int CFG_CURSOR = 1;
    localparam int CFG_BLINK = 2;
    localparam int CFG_FONT = 3;
    localparam int CFG_INVERT = 4;
    localparam int CFG_FOURLINE = 5;
    localparam int CFG_SHIFT_LSB = 8;
    localparam int CFG_SCROLL_LSB = 12;
    localparam int CFG_EXT = 16;
    localparam int CFG_SHSEL = 17;
    localparam int CFG_TWOLINE = 18;
    localparam int CFG_MOVES_LSB = 20;
    // ----------------------------------------
    // reset values and timing
    // ----------------------------------------
    localparam logic [6:0] ADDR_RST = 7'h00;
    localparam logic [7:0] SHIFT_CNT_RST = 8'h00;
    localparam int CLK_MHZ = 200;
    localparam int EXEC_NS = 39000;
    localparam int EXEC_CYC = (EXEC_NS * CLK_MHZ) / 1000;
    localparam int HALF_OSC_NS = 1852;
    localparam int HALF_OSC_CYC = (HALF_OSC_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 14;

    typedef struct packed {
        logic display_on;
        logic cursor_on;
        logic blink_on;
        logic font_width_sel;
        logic cursor_invert;
        logic four_line_mode;
        logic two_line_mode;
        logic [3:0] shift_en;
        logic [3:0] scroll_en;
    } lcdc_disp_t;

    typedef struct packed {
        logic valid;
        logic display_sel;
        logic right;
    } lcdc_move_t;
endpackage

// [lcdc_decoder.sv]
// Purpose: display-control instruction decoder with busy indication
// Assumes: host keeps classic wishbone single-cycle framing
// Notes: a write to ADR_CMD is one instruction byte
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Contract
// [RULE_01] display, cursor, blink bits when extension clear
// [RULE_02] extended set: font width, cursor inversion
// [RULE_03] low extended bit selects four-line mode
// [RULE_04] cursor/display shift, direction, 39us busy
// [RULE_05] shift enable per line, bit0 line one
// [RULE_06] scroll enable per line, bit0 line one
// [RULE_07] busy shown on top status bit
// [RULE_08] host polls busy before next instruction
// [RULE_09] host waits half oscillator after ready
// [RULE_10] function set writes extension select
// [RULE_11] function set writes shift/scroll select; code writes it only when the function set's extension bit cmd[2] is clear
// [RULE_12] status read gives busy and address
// [RULE_13] don't-care bits ignored, settings persist
// [RULE_14] busy held for full execution time
module lcdc_decoder (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output lcdc_pkg::lcdc_disp_t disp_o,
    output lcdc_pkg::lcdc_move_t move_o,
    output logic busy_indication_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [1:0] {
        LCDC_IDLE = 2'b00,
        LCDC_EXEC = 2'b01,
        LCDC_GAP = 2'b11
    } lcdc_state_t;

    lcdc_state_t state_ff;
    lcdc_state_t nxt_state;
    logic [lcdc_pkg::CNT_W-1:0] cnt_ff;
    logic [lcdc_pkg::CNT_W-1:0] nxt_cnt;
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [2:0] disp_ctl_ff;
    logic [2:0] ext_fn_ff;
    logic two_line_ff;
    logic [3:0] shift_en_ff;
    logic [3:0] scroll_en_ff;
    lcdc_pkg::lcdc_disp_t disp_w;
    lcdc_pkg::lcdc_move_t move_ff;
    logic extension_select_ff;
    logic shift_scroll_select_ff;
    logic [6:0] address_counter_ff;
    logic [7:0] moves_ff;
    logic req;
    logic cmd_wr;
    logic [7:0] cmd;
    logic busy;

    function automatic logic [31:0] status_word(input logic b, input logic [6:0] a);
        status_word = {24'h000000, b, a};
    endfunction

    assign req = cyc_i && stb_i && !ack_ff;
    assign cmd_wr = req && we_i && sel_i[0] && (adr_i == lcdc_pkg::ADR_CMD);
    assign cmd = dat_i[7:0];
    assign busy = (state_ff == LCDC_EXEC);

    // ----------------------------------------
    // busy timing
    // ----------------------------------------
    // instructions arriving while busy are dropped; the host is expected to poll
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            LCDC_IDLE: begin
                if (cmd_wr) begin
                    nxt_state = LCDC_EXEC; // RULE_14
                    nxt_cnt = lcdc_pkg::CNT_W'(lcdc_pkg::EXEC_CYC - 1);
                end
            end
            LCDC_EXEC: begin
                if (cnt_ff == '0) begin
                    nxt_state = LCDC_GAP;
                    nxt_cnt = lcdc_pkg::CNT_W'(lcdc_pkg::HALF_OSC_CYC - 1);
                end else begin
                    nxt_cnt = cnt_ff - 1'b1; // RULE_14
                end
            end
            LCDC_GAP: begin
                // half oscillator period of settling the host must leave
                if (cnt_ff == '0) begin
                    nxt_state = LCDC_IDLE; // RULE_09
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            default: begin
                nxt_state = LCDC_IDLE;
                nxt_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= LCDC_IDLE;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // ----------------------------------------
    // instruction decode
    // ----------------------------------------
    // ----------------------------------------
    // instruction classes
    // ----------------------------------------
    function automatic logic is_func_set(input logic [7:0] c);
        is_func_set = (c[7:5] == 3'h1);
    endfunction

    function automatic logic is_disp_ctl(input logic [7:0] c);
        is_disp_ctl = (c[7:3] == 5'h01);
    endfunction

    function automatic logic is_shift_grp(input logic [7:0] c);
        is_shift_grp = (c[7:4] == 4'h1);
    endfunction

    // layout kept in one place so software sees the package positions
    function automatic logic [31:0] config_word(
        input lcdc_pkg::lcdc_disp_t d,
        input logic ext,
        input logic shsel,
        input logic [7:0] moves
    );
        config_word = '0;
        config_word[lcdc_pkg::CFG_DISPLAY] = d.display_on;
        config_word[lcdc_pkg::CFG_CURSOR] = d.cursor_on;
        config_word[lcdc_pkg::CFG_BLINK] = d.blink_on;
        config_word[lcdc_pkg::CFG_FONT] = d.font_width_sel;
        config_word[lcdc_pkg::CFG_INVERT] = d.cursor_invert;
        config_word[lcdc_pkg::CFG_FOURLINE] = d.four_line_mode;
        config_word[lcdc_pkg::CFG_SHIFT_LSB +: 4] = d.shift_en;
        config_word[lcdc_pkg::CFG_SCROLL_LSB +: 4] = d.scroll_en;
        config_word[lcdc_pkg::CFG_EXT] = ext;
        config_word[lcdc_pkg::CFG_SHSEL] = shsel;
        config_word[lcdc_pkg::CFG_TWOLINE] = d.two_line_mode;
        config_word[lcdc_pkg::CFG_MOVES_LSB +: 8] = moves;
    endfunction

    // ----------------------------------------
    // instruction decode
    // ----------------------------------------
    logic accept;
    logic acc_func;
    logic acc_disp;
    logic acc_shift;
    logic addr_wr;
    logic rd_req;

    // classes are disjoint, so no priority is needed between them
    assign accept = cmd_wr && (state_ff == LCDC_IDLE); // RULE_08
    assign acc_func = accept && is_func_set(cmd);
    assign acc_disp = accept && is_disp_ctl(cmd);
    assign acc_shift = accept && is_shift_grp(cmd);
    assign addr_wr = req && we_i && sel_i[0] && (adr_i == lcdc_pkg::ADR_ADDR);
    assign rd_req = req && !we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            extension_select_ff <= 1'b0;
        end else if (acc_func) begin
            extension_select_ff <= cmd[2]; // RULE_10
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_scroll_select_ff <= 1'b0;
        end else if (acc_func && !cmd[2]) begin
            shift_scroll_select_ff <= cmd[1]; // RULE_11
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            two_line_ff <= 1'b0;
        end else if (acc_func) begin
            two_line_ff <= cmd[3]; // RULE_03
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            disp_ctl_ff <= 3'h0;
        end else if (acc_disp && !extension_select_ff) begin
            disp_ctl_ff <= cmd[2:0]; // RULE_01
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_fn_ff <= 3'h0;
        end else if (acc_disp && extension_select_ff) begin
            ext_fn_ff <= cmd[2:0]; // RULE_02 RULE_03
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_en_ff <= 4'h0;
        end else if (acc_shift && extension_select_ff && shift_scroll_select_ff) begin
            shift_en_ff <= cmd[3:0]; // RULE_05
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scroll_en_ff <= 4'h0;
        end else if (acc_shift && extension_select_ff && !shift_scroll_select_ff) begin
            scroll_en_ff <= cmd[3:0]; // RULE_06
        end
    end

    // low two bits of the move are ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            move_ff <= '0;
        end else begin
            move_ff.valid <= acc_shift && !extension_select_ff; // RULE_04 RULE_13
            if (acc_shift && !extension_select_ff) begin
                move_ff.display_sel <= cmd[3]; // RULE_04
                move_ff.right <= cmd[2]; // RULE_04
            end
        end
    end

    // wraps silently; only a debug aid
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            moves_ff <= lcdc_pkg::SHIFT_CNT_RST;
        end else if (acc_shift && !extension_select_ff) begin
            moves_ff <= moves_ff + 8'h01;
        end
    end

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    // one wait state; any address answers, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            address_counter_ff <= lcdc_pkg::ADDR_RST;
        end else if (addr_wr) begin
            address_counter_ff <= dat_i[6:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= '0;
        end else if (rd_req) begin
            case (adr_i)
                lcdc_pkg::ADR_STATUS: begin
                    dat_ff <= status_word(busy, address_counter_ff); // RULE_07 RULE_12
                end
                lcdc_pkg::ADR_CONFIG: begin
                    dat_ff <= config_word(disp_w, extension_select_ff,
                                          shift_scroll_select_ff, moves_ff);
                end
                lcdc_pkg::ADR_ADDR: begin
                    dat_ff <= status_word(1'b0, address_counter_ff);
                end
                default: begin
                    dat_ff <= '0;
                end
            endcase
        end
    end

    assign disp_w = {disp_ctl_ff, ext_fn_ff, two_line_ff, shift_en_ff, scroll_en_ff};
    assign ack_o = ack_ff;
    assign dat_o = dat_ff;
    assign disp_o = disp_w;
    assign move_o = move_ff;
    assign busy_indication_o = busy;
endmodule

// [lcdc_decoder_asserts.sv]
// Purpose: port checks for the decoder
// Assumes: classic wishbone single cycles
// Notes: a counter stands in for the long busy
`timescale 1ns/1ps
module lcdc_decoder_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire lcdc_pkg::lcdc_disp_t disp_o,
    input wire lcdc_pkg::lcdc_move_t move_o,
    input wire logic busy_indication_o
);
    int busy_n_ff;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req; cyc_i && stb_i && !ack_o; endsequence
    sequence s_take; ack_o && $rose(busy_indication_o); endsequence
    // too long to unroll, so count it
    always_ff @(posedge clk_i) begin
        busy_n_ff <= (rst_i || !busy_indication_o) ? 0 : busy_n_ff + 1;
    end
    a_ack_next: assert property (s_req |=> ack_o) else $error("no ack");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("long ack");
    a_busy_cause: assert property ($rose(busy_indication_o) |->
        ack_o && $past(we_i) && $past(adr_i) == lcdc_pkg::ADR_CMD) else $error("stray busy");
    a_busy_len: assert property ($fell(busy_indication_o) |->
        busy_n_ff == lcdc_pkg::EXEC_CYC) else $error("busy length");
    a_status_bit: assert property (ack_o && !$past(we_i) &&
        $past(adr_i) == lcdc_pkg::ADR_STATUS |-> dat_o[7] == $past(busy_indication_o))
        else $error("status busy bit");
    a_move_pulse: assert property (move_o.valid |=> !move_o.valid) else $error("long move");
    a_move_cause: assert property ($rose(move_o.valid) |-> s_take) else $error("stray move");
    a_disp_hold: assert property (!$stable(disp_o) |-> s_take) else $error("stray change");
endmodule
bind lcdc_decoder lcdc_decoder_asserts chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .disp_o(disp_o), .move_o(move_o), .busy_indication_o(busy_indication_o));

// [lcdc_host.sv]
// Purpose: host processor model on wishbone
// Assumes: slave answers with ack
// Notes: polls busy, then waits the gap
`timescale 1ns/1ps
module lcdc_host (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [3:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = 43'h0;
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'h3, w, a, 4'hF, d};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        r = dat_i;
        // released lines other than sel_o show the inverse; sel_o keeps its 4'hF
        {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'h0, ~w, ~a, ~d};
        @(posedge clk_i);
    endtask
    task automatic ready();
        logic [31:0] r;
        do bus(1'b0, lcdc_pkg::ADR_STATUS, 32'h0, r); while (r[7] !== 1'b0);
        repeat (lcdc_pkg::HALF_OSC_CYC) @(posedge clk_i);
    endtask
    task automatic ins(input logic [7:0] b);
        logic [31:0] r;
        bus(1'b1, lcdc_pkg::ADR_CMD, {24'h0, b}, r);
        ready();
    endtask
endmodule

// [lcd_display_control_decoder_tb.sv]
// Purpose: random and corner runs of the decoder
// Assumes: host model paces the commands
// Notes: nine commands fill most of the run
`timescale 1ns/1ps
module lcd_display_control_decoder_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, busy, ext_sel, shsel;
    logic [3:0] adr, sel;
    logic [31:0] wd, rd, r;
    logic [7:0] x;
    lcdc_pkg::lcdc_disp_t disp, exp;
    lcdc_pkg::lcdc_move_t move, mv;
    int n_fail = 0;
    int check_count = 0;
    int t = 0;
    lcdc_decoder dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rd), .ack_o(ack), .disp_o(disp),
        .move_o(move), .busy_indication_o(busy));
    lcdc_host host_u (.clk_i(clk_i), .ack_i(ack), .dat_i(rd), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (move.valid === 1'b1) mv <= move;
        t <= t + 1;
        if (t == 90000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] w);
        check_count++;
        if (s !== w) begin
            n_fail++;
            $display("mismatch %0t: saw %h want %h", $time, s, w);
        end
    endtask
    function automatic void upd(input logic [7:0] b);
        if (b[7:5] == 3'h1) begin
            ext_sel = b[2];
            exp.two_line_mode = b[3];
            if (!b[2]) shsel = b[1];
        end else if (b[7:3] == 5'h01) begin
            if (ext_sel) {exp.font_width_sel, exp.cursor_invert, exp.four_line_mode} = b[2:0];
            else {exp.display_on, exp.cursor_on, exp.blink_on} = b[2:0];
        end else if (b[7:4] == 4'h1 && ext_sel) begin
            if (shsel) exp.shift_en = b[3:0];
            else exp.scroll_en = b[3:0];
        end
    endfunction
    function automatic logic [31:0] cfg_exp(input logic [7:0] n);
        cfg_exp = '0;
        cfg_exp[lcdc_pkg::CFG_DISPLAY] = exp.display_on;
        cfg_exp[lcdc_pkg::CFG_CURSOR] = exp.cursor_on;
        cfg_exp[lcdc_pkg::CFG_BLINK] = exp.blink_on;
        cfg_exp[lcdc_pkg::CFG_FONT] = exp.font_width_sel;
        cfg_exp[lcdc_pkg::CFG_INVERT] = exp.cursor_invert;
        cfg_exp[lcdc_pkg::CFG_FOURLINE] = exp.four_line_mode;
        cfg_exp[lcdc_pkg::CFG_SHIFT_LSB +: 4] = exp.shift_en;
        cfg_exp[lcdc_pkg::CFG_SCROLL_LSB +: 4] = exp.scroll_en;
        cfg_exp[lcdc_pkg::CFG_EXT] = ext_sel;
        cfg_exp[lcdc_pkg::CFG_SHSEL] = shsel;
        cfg_exp[lcdc_pkg::CFG_TWOLINE] = exp.two_line_mode;
        cfg_exp[lcdc_pkg::CFG_MOVES_LSB +: 8] = n;
    endfunction
    task automatic run(input logic [7:0] b);
        host_u.ins(b);
        upd(b);
        chk({17'h0, disp}, {17'h0, exp});
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(7783));
        exp = '0;
        mv = '0;
        {ext_sel, shsel} = 2'h0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        x = {5'h01, 3'($urandom_range(7))};
        host_u.bus(1'b1, lcdc_pkg::ADR_CMD, {24'h0, x}, r);
        chk({31'h0, busy}, 32'h1);
        host_u.bus(1'b0, lcdc_pkg::ADR_STATUS, 32'h0, r);
        chk(r, 32'h80);
        // early write breaks the polling rule on purpose
        host_u.bus(1'b1, lcdc_pkg::ADR_CMD, {29'h1, ~x[2:0]}, r);
        host_u.ready();
        upd(x);
        chk({17'h0, disp}, {17'h0, exp});
        $display("display test done");
        run(8'h1F);
        chk({29'h0, mv}, 32'h7);
        run(8'h22);
        run(8'h24);
        run({5'h01, 3'($urandom_range(7))});
        run({4'h1, 4'($urandom_range(15))});
        run(8'h20);
        run(8'h24);
        run({4'h1, 4'($urandom_range(15))});
        $display("extended test done");
        x = 8'($urandom_range(127));
        host_u.bus(1'b1, lcdc_pkg::ADR_ADDR, {24'h0, x}, r);
        host_u.bus(1'b0, lcdc_pkg::ADR_STATUS, 32'h0, r);
        chk(r, {25'h0, x[6:0]});
        host_u.bus(1'b0, lcdc_pkg::ADR_CONFIG, 32'h0, r);
        chk(r, cfg_exp(8'h01));
        $display("readback test done");
        test_done();
    end
endmodule
